// file: bench/afs_host.sv
// Control port host model: two-wire master that drives clock and pulls data low
`timescale 1ns/1ps
module afs_host (
  // Clock
  input  wire logic i_clk,
  // Bus pins
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // Six clocks a step keeps each bus phase above the four the port needs
  task automatic hold();
    repeat (6) @(negedge i_clk);
  endtask
  task automatic start();
    hold();
    o_sda_low = 1'b0;
    hold();
    o_scl = 1'b1;
    hold();
    o_sda_low = 1'b1;
    hold();
    o_scl = 1'b0;
  endtask
  task automatic stop();
    hold();
    o_sda_low = 1'b1;
    hold();
    o_scl = 1'b1;
    hold();
    o_sda_low = 1'b0;
    hold();
  endtask
  // Byte plus acknowledge slot, MSB first; a one releases the line
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      hold();
      o_sda_low = ~tx[i];
      hold();
      o_scl = 1'b1;
      hold();
      rx[i] = i_sda;
      hold();
      o_scl = 1'b0;
    end
  endtask
endmodule

// file: bench/tb_afs_regs.sv
// Bench for the fault status and clip level register slice
`timescale 1ns/1ps
module tb_afs_regs;
  logic        i_clk     = 1'b0;
  logic        i_reset   = 1'b1;
  logic        shut_n    = 1'b0;
  logic        clk_bad   = 1'b0;
  logic        dc_over   = 1'b0;
  logic        temp_over = 1'b0;
  logic [11:0] cur       = 12'h000;
  logic        s_valid   = 1'b0;
  logic [23:0] s_in      = 24'h000000;
  logic        scl;
  logic        host_low;
  logic        sda_oe;
  logic        s_out_valid;
  logic        amp_run;
  logic [23:0] s_out;
  logic [19:0] thr;
  logic [3:0]  flags;
  logic [11:0] trip;
  logic [23:0] smp [3] = '{24'h0fd6aa, 24'h800000, 24'h000123};
  logic [23:0] want [3] = '{24'h0fd6a9, 24'hf02957, 24'h000123};
  int          miscompares = 0;
  int          check_count = 0;
  int          cycles      = 0;
  // Open-drain data line with its pull-up
  wire         sda = !(sda_oe || host_low);

  always #12.5 i_clk = ~i_clk;

  afs_host i_host (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(host_low));
  afs_regs i_dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_scl(scl), .i_sda(sda), .o_sda(),
    .o_sda_oe(sda_oe), .i_addr_strap(1'b0), .i_amplifier_shutdown_n(shut_n),
    .i_clk_invalid(clk_bad), .i_dc_over(dc_over), .i_temp_over(temp_over),
    .i_out_current(cur), .i_sample_valid(s_valid), .i_sample(s_in),
    .o_sample_valid(s_out_valid), .o_sample(s_out), .o_amp_run(amp_run),
    .o_clip_threshold_level(thr), .o_fault_flags(flags));

  function automatic logic [23:0] st();
    return {8'h00, flags, 11'h000, amp_run};
  endfunction
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic settle();
    repeat (6) @(negedge i_clk);
  endtask
  task automatic send(input logic [7:0] b);
    logic [8:0] rx;
    i_host.xfer({b, 1'b1}, rx);
    check({23'h0, rx[0]}, 24'h0);
  endtask
  // Sends n bytes of d, upper byte first, to pointer a onwards
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input int n);
    i_host.start();
    send({afs_pkg::DEV_ADDR_BASE, 1'b0});
    send(a);
    for (int i = n - 1; i >= 0; i--) send(d[8*i +: 8]);
    i_host.stop();
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [8:0] rx;
    i_host.start();
    send({afs_pkg::DEV_ADDR_BASE, 1'b0});
    send(a);
    i_host.start();
    send({afs_pkg::DEV_ADDR_BASE, 1'b1});
    // Last byte is not acknowledged, so the port lets go before stop
    i_host.xfer(9'h1ff, rx);
    i_host.stop();
    check({16'h0, rx[8:1]}, {16'h0, exp});
  endtask
  task automatic toggle(input logic by_reg);
    if (by_reg) begin
      wr(8'h01, 16'h0000, 1);
      wr(8'h01, 16'h0001, 1);
    end else begin
      shut_n = 1'b0;
      settle();
      shut_n = 1'b1;
    end
    settle();
  endtask

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      wrap_up();
    end
  end

  initial begin
    repeat (2) @(negedge i_clk);
    i_reset = 1'b0;
    repeat (4) @(negedge i_clk);
    check(st(), 24'h0);
    check({4'h0, thr}, 24'h0fffff);
    rd_chk(8'h08, 8'h00);
    rd_chk(8'h10, 8'hff);
    rd_chk(8'h11, 8'hfc);
    wr(8'h02, 16'h00ff, 1);
    rd_chk(8'h02, 8'hfc);
    rd_chk(8'h01, 8'h00);
    wr(8'h10, 16'h5aa7, 2);
    rd_chk(8'h11, 8'ha4);
    check({4'h0, thr}, 24'h0fd6a9);
    wr(8'h01, 16'h0001, 1);
    shut_n = 1'b1;
    settle();
    check(st(), 24'h000001);
    for (int c = 0; c < 4; c++) begin
      trip = 12'((int'(afs_pkg::OC_NOMINAL) / 4) * (4 - c));
      wr(8'h08, {8'h00, 2'b00, c[1:0], 4'hf}, 1);
      rd_chk(8'h08, {2'b00, c[1:0], 4'h0});
      cur = trip;
      settle();
      check(st(), 24'h000001);
      cur = trip + 12'h001;
      settle();
      cur = 12'h000;
      settle();
      check(st(), 24'h004000);
      rd_chk(8'h08, {2'b00, c[1:0], 4'h4});
      toggle(c[0]);
      check(st(), 24'h000001);
    end
    for (int k = 0; k < 3; k++) begin
      temp_over = (k == 0);
      dc_over = (k == 1);
      clk_bad = (k == 2);
      settle();
      check(st(), 24'h001000 << (k + (k == 2)));
      temp_over = 1'b0;
      dc_over = 1'b0;
      clk_bad = 1'b0;
      settle();
      check(st(), (k == 2) ? 24'h000001 : 24'h001000 << k);
      toggle(k[0]);
      check(st(), 24'h000001);
    end
    foreach (smp[i]) begin
      s_in = smp[i];
      s_valid = 1'b1;
      @(negedge i_clk);
      s_valid = 1'b0;
      check({23'h0, s_out_valid}, 24'h000001);
      check(s_out, want[i]);
    end
    wrap_up();
  end
endmodule

// file: rtl/afs_clipper.sv
// Sample clipper: limits each sample magnitude to the clip threshold
`timescale 1ns/1ps
module afs_clipper (
  // Clock and reset
  input  wire logic                                i_clk,
  input  wire logic                                i_reset,
  // Sample in
  input  wire logic                                i_valid,
  input  wire logic signed [afs_pkg::SAMPLE_W-1:0] i_sample,
  input  wire logic        [afs_pkg::CLIP_W-1:0]   i_threshold,
  // Sample out
  output logic                                     o_valid,
  output logic signed      [afs_pkg::SAMPLE_W-1:0] o_sample
);

  localparam int PAD_W = afs_pkg::SAMPLE_W - afs_pkg::CLIP_W;

  logic                                valid_ff;
  logic signed [afs_pkg::SAMPLE_W-1:0] sample_ff;

  wire signed [afs_pkg::SAMPLE_W-1:0] pos_lim = $signed({{PAD_W{1'b0}}, i_threshold});
  wire signed [afs_pkg::SAMPLE_W-1:0] neg_lim = -pos_lim;
  wire signed [afs_pkg::SAMPLE_W-1:0] nxt_sample = (i_sample > pos_lim) ? pos_lim :
                                                   (i_sample < neg_lim) ? neg_lim : i_sample;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      valid_ff  <= 1'b0;
      sample_ff <= '0;
    end else begin
      valid_ff  <= i_valid;
      sample_ff <= i_valid ? nxt_sample : sample_ff;
    end
  end

  assign o_valid  = valid_ff;
  assign o_sample = sample_ff;

  a_clip_bound: assert property (@(posedge i_clk) disable iff (i_reset)
    i_valid |=> (o_sample <= $past(pos_lim)) && (o_sample >= $past(neg_lim)))
    else $error("clipped sample exceeds threshold");

endmodule

// file: rtl/afs_ctrl_port.sv
// Two-wire control port slave: device address, register pointer, write and read bytes
`timescale 1ns/1ps
module afs_ctrl_port (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  // Pins
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_oe,
  // Device address
  input  wire logic [6:0] i_dev_addr,
  // Register side
  output logic [7:0]      o_reg_addr,
  output logic            o_wr_stb,
  output logic [7:0]      o_wr_data,
  input  wire logic [7:0] i_rd_data
);

  logic [2:0] scl_sync_ff;
  logic [2:0] sda_sync_ff;
  afs_pkg::afs_port_state_t state_ff;
  logic [7:0] shift_ff;
  logic [3:0] cnt_ff;
  logic [1:0] phase_ff;
  logic       rw_ff;
  logic       acked_ff;
  logic       sda_oe_ff;
  logic [7:0] ptr_ff;
  logic       wr_stb_ff;
  logic [7:0] wr_data_ff;

  // Edges only look at the second and third stage
  wire scl_rise = scl_sync_ff[1] & ~scl_sync_ff[2];
  wire scl_fall = ~scl_sync_ff[1] & scl_sync_ff[2];
  wire sda_now  = sda_sync_ff[1];
  wire start_cd = scl_sync_ff[1] & scl_sync_ff[2] & ~sda_sync_ff[1] & sda_sync_ff[2];
  wire stop_cd  = scl_sync_ff[1] & scl_sync_ff[2] & sda_sync_ff[1] & ~sda_sync_ff[2];
  wire addr_hit = (shift_ff[7:1] == i_dev_addr);

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      scl_sync_ff <= 3'h7;
      sda_sync_ff <= 3'h7;
    end else begin
      scl_sync_ff <= {scl_sync_ff[1:0], i_scl};
      sda_sync_ff <= {sda_sync_ff[1:0], i_sda};
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_ff   <= afs_pkg::AFS_IDLE;
      shift_ff   <= 8'h00;
      cnt_ff     <= 4'h0;
      phase_ff   <= 2'h0;
      rw_ff      <= 1'b0;
      acked_ff   <= 1'b0;
      sda_oe_ff  <= 1'b0;
      ptr_ff     <= 8'h00;
      wr_stb_ff  <= 1'b0;
      wr_data_ff <= 8'h00;
    end else begin
      wr_stb_ff <= 1'b0;
      if (start_cd) begin
        // Repeated start keeps the pointer for a following read
        state_ff  <= afs_pkg::AFS_RX;
        cnt_ff    <= 4'h0;
        phase_ff  <= 2'h0;
        sda_oe_ff <= 1'b0;
      end else if (stop_cd) begin
        state_ff  <= afs_pkg::AFS_IDLE;
        sda_oe_ff <= 1'b0;
      end else begin
        case (state_ff)
          afs_pkg::AFS_RX: begin
            if (scl_rise) begin
              shift_ff <= {shift_ff[6:0], sda_now};
              cnt_ff   <= cnt_ff + 4'h1;
            end else if (scl_fall && cnt_ff == 4'h8) begin
              sda_oe_ff <= 1'b1;
              state_ff  <= afs_pkg::AFS_ACK;
              if (phase_ff == 2'h0) begin
                rw_ff <= shift_ff[0];
                if (!addr_hit) begin
                  sda_oe_ff <= 1'b0;
                  state_ff  <= afs_pkg::AFS_IDLE;
                end
              end else if (phase_ff == 2'h1) begin
                ptr_ff <= shift_ff;
              end else begin
                wr_stb_ff  <= 1'b1;
                wr_data_ff <= shift_ff;
              end
            end
          end
          afs_pkg::AFS_ACK: begin
            if (scl_fall) begin
              cnt_ff   <= 4'h0;
              phase_ff <= (phase_ff == 2'h0) ? 2'h1 : 2'h2;
              if (phase_ff == 2'h2) begin
                ptr_ff <= ptr_ff + 8'h01;
              end
              if (rw_ff) begin
                shift_ff  <= i_rd_data;
                sda_oe_ff <= ~i_rd_data[7];
                ptr_ff    <= ptr_ff + 8'h01;
                cnt_ff    <= 4'h1;
                state_ff  <= afs_pkg::AFS_TX;
              end else begin
                sda_oe_ff <= 1'b0;
                state_ff  <= afs_pkg::AFS_RX;
              end
            end
          end
          afs_pkg::AFS_TX: begin
            if (scl_fall) begin
              if (cnt_ff == 4'h8) begin
                sda_oe_ff <= 1'b0;
                state_ff  <= afs_pkg::AFS_TX_ACK;
              end else begin
                sda_oe_ff <= ~shift_ff[6];
                shift_ff  <= {shift_ff[6:0], 1'b0};
                cnt_ff    <= cnt_ff + 4'h1;
              end
            end
          end
          afs_pkg::AFS_TX_ACK: begin
            if (scl_rise) begin
              acked_ff <= ~sda_now;
            end else if (scl_fall) begin
              if (acked_ff) begin
                shift_ff  <= i_rd_data;
                sda_oe_ff <= ~i_rd_data[7];
                ptr_ff    <= ptr_ff + 8'h01;
                cnt_ff    <= 4'h1;
                state_ff  <= afs_pkg::AFS_TX;
              end else begin
                state_ff <= afs_pkg::AFS_IDLE;
              end
            end
          end
          default: begin
            state_ff <= afs_pkg::AFS_IDLE;
          end
        endcase
      end
    end
  end

  assign o_sda_oe   = sda_oe_ff;
  assign o_reg_addr = ptr_ff;
  assign o_wr_stb   = wr_stb_ff;
  assign o_wr_data  = wr_data_ff;

endmodule

// file: rtl/afs_pkg.sv
// Shared constants for the amplifier fault status and clip level register slice
package afs_pkg;

  // Widths
  localparam int REG_W    = 8;
  localparam int CUR_W    = 12;
  localparam int CLIP_W   = 20;
  localparam int SAMPLE_W = 24;

  // Control port device address, low bit comes from the address strap
  localparam logic [6:0] DEV_ADDR_BASE = 7'h36;

  // Register offsets
  localparam logic [7:0] ADDR_RUN_CTRL   = 8'h01;
  localparam logic [7:0] ADDR_CLIP_HIGH  = 8'h02;
  localparam logic [7:0] ADDR_RSVD_A     = 8'h07;
  localparam logic [7:0] ADDR_FAULT      = 8'h08;
  localparam logic [7:0] ADDR_RSVD_FIRST = 8'h09;
  localparam logic [7:0] ADDR_RSVD_LAST  = 8'h0f;
  localparam logic [7:0] ADDR_CLIP_MID   = 8'h10;
  localparam logic [7:0] ADDR_CLIP_LOW   = 8'h11;

  // Field positions
  localparam int RUN_CTRL_BIT   = 0;
  localparam int FLT_SCALE_LSB  = 4;
  localparam int FLT_CLK_BIT    = 3;
  localparam int FLT_OC_BIT     = 2;
  localparam int FLT_DC_BIT     = 1;
  localparam int FLT_OT_BIT     = 0;
  localparam int CLIP_FIELD_LSB = 2;

  // Values after reset
  localparam logic [1:0] SCALE_RESET     = 2'h0;
  localparam logic       RUN_CTRL_RESET  = 1'b0;
  localparam logic [5:0] CLIP_HIGH_RESET = 6'h3f;
  localparam logic [7:0] CLIP_MID_RESET  = 8'hff;
  localparam logic [5:0] CLIP_LOW_RESET  = 6'h3f;

  // Over-current trip scale codes
  localparam logic [1:0] SCALE_FULL = 2'h0;
  localparam logic [1:0] SCALE_75   = 2'h1;
  localparam logic [1:0] SCALE_50   = 2'h2;
  localparam logic [1:0] SCALE_25   = 2'h3;

  // Nominal over-current trip level in current-sense units, arbitrary default
  localparam logic [CUR_W-1:0] OC_NOMINAL = 12'hc00;

  // Control port sequencer states
  typedef enum logic [2:0] {
    AFS_IDLE,
    AFS_RX,
    AFS_ACK,
    AFS_TX,
    AFS_TX_ACK
  } afs_port_state_t;

endpackage

// file: rtl/afs_regs.sv
// Amplifier fault status, over-current scale and clip level registers
//
// How it works
// - Fault register bits 7:6 read zero; host writes them as zero.
// - Scale field 5:4: 01 trips at 75%, 10 at 50%, 11 at 25%.
// - Scale field resets to 00, the full nominal trip level.
// - Clock fault bit 3 follows the invalid-clock detector.
// - Clock fault never latches; it clears and the amplifier resumes alone.
// - Over-current bit 2 sets when output current passes the scaled trip level.
// - Over-current latches and stops the amplifier until shutdown is toggled.
// - Offset bit 1 sets when speaker DC offset passes its threshold.
// - Offset fault latches and halts outputs until shutdown is toggled.
// - Over-temperature bit 0 sets when die temperature passes its limit.
// - Over-temperature latches and halts the amplifier until shutdown is toggled.
// - The four fault bits are read-only and reset to zero.
// - Clip threshold is 20 bits built from three registers.
// - Register 0x10 supplies threshold bits 13:6.
// - Register 0x11 bits 7:2 supply threshold bits 5:0; bits 1:0 stay zero.
// - Shutdown follows a low shutdown pin or a cleared run control bit.
`timescale 1ns/1ps
module afs_regs (
  // Clock and reset
  input  wire logic                                i_clk,
  input  wire logic                                i_reset,
  // Control port pins
  input  wire logic                                i_scl,
  input  wire logic                                i_sda,
  output logic                                     o_sda,
  output logic                                     o_sda_oe,
  input  wire logic                                i_addr_strap,
  // Amplifier pins and monitors
  input  wire logic                                i_amplifier_shutdown_n,
  input  wire logic                                i_clk_invalid,
  input  wire logic                                i_dc_over,
  input  wire logic                                i_temp_over,
  input  wire logic        [afs_pkg::CUR_W-1:0]    i_out_current,
  // Audio datapath
  input  wire logic                                i_sample_valid,
  input  wire logic signed [afs_pkg::SAMPLE_W-1:0] i_sample,
  output logic                                     o_sample_valid,
  output logic signed      [afs_pkg::SAMPLE_W-1:0] o_sample,
  // Status towards the power stage
  output logic                                     o_amp_run,
  output logic             [afs_pkg::CLIP_W-1:0]   o_clip_threshold_level,
  output logic             [3:0]                   o_fault_flags
);

  localparam int NLATCH = 3;

  // Pin synchronisers: stage one feeds stage two only
  logic [4:0] pin_meta_ff;
  logic [4:0] pin_sync_ff;
  wire [4:0] pin_raw = {i_addr_strap, i_amplifier_shutdown_n, i_clk_invalid,
                        i_dc_over, i_temp_over};
  wire addr_sync   = pin_sync_ff[4];
  wire sd_pin_sync = pin_sync_ff[3];
  wire clk_bad     = pin_sync_ff[2];

  // Register state
  logic [1:0]              overcurrent_limit_scale_ff;
  logic                    run_ctrl_ff;
  logic [5:0]              clip_high_ff;
  logic [7:0]              clip_mid_ff;
  logic [5:0]              clip_low_ff;
  logic                    clock_fault_flag_ff;
  logic [NLATCH-1:0]       latched_ff;
  logic                    run_prev_ff;
  logic                    amp_run_ff;
  logic [afs_pkg::CLIP_W-1:0] clip_level_ff;
  logic [6:0]              dev_addr_ff;

  // Port interface
  logic [7:0] reg_addr;
  logic       wr_stb;
  logic [7:0] wr_data;
  logic [7:0] rd_data;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pin_meta_ff <= 5'h00;
      pin_sync_ff <= 5'h00;
    end else begin
      pin_meta_ff <= pin_raw;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // Strap is followed every cycle after release, from the synchronised copy
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      dev_addr_ff <= afs_pkg::DEV_ADDR_BASE;
    end else begin
      dev_addr_ff <= {afs_pkg::DEV_ADDR_BASE[6:1], addr_sync};
    end
  end

  afs_ctrl_port u_port (
    .i_clk      (i_clk),
    .i_reset    (i_reset),
    .i_scl      (i_scl),
    .i_sda      (i_sda),
    .o_sda_oe   (o_sda_oe),
    .i_dev_addr (dev_addr_ff),
    .o_reg_addr (reg_addr),
    .o_wr_stb   (wr_stb),
    .o_wr_data  (wr_data),
    .i_rd_data  (rd_data)
  );

  // Address decode
  wire hit_run   = (reg_addr == afs_pkg::ADDR_RUN_CTRL);
  wire hit_high  = (reg_addr == afs_pkg::ADDR_CLIP_HIGH);
  wire hit_fault = (reg_addr == afs_pkg::ADDR_FAULT);
  wire hit_mid   = (reg_addr == afs_pkg::ADDR_CLIP_MID);
  wire hit_low   = (reg_addr == afs_pkg::ADDR_CLIP_LOW);

  // Fault register image; top two bits are hard zero
  wire [7:0] fault_image = {2'h0, overcurrent_limit_scale_ff, clock_fault_flag_ff,
                            latched_ff};

  // Reserved and unmapped locations read zero and ignore writes
  assign rd_data = hit_run   ? {7'h00, run_ctrl_ff} :
                   hit_high  ? {clip_high_ff, 2'h0} :
                   hit_fault ? fault_image :
                   hit_mid   ? clip_mid_ff :
                   hit_low   ? {clip_low_ff, 2'h0} : 8'h00;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      overcurrent_limit_scale_ff <= afs_pkg::SCALE_RESET;
      run_ctrl_ff                <= afs_pkg::RUN_CTRL_RESET;
      clip_high_ff               <= afs_pkg::CLIP_HIGH_RESET;
      clip_mid_ff                <= afs_pkg::CLIP_MID_RESET;
      clip_low_ff                <= afs_pkg::CLIP_LOW_RESET;
    end else if (wr_stb) begin
      if (hit_run) begin
        run_ctrl_ff <= wr_data[afs_pkg::RUN_CTRL_BIT];
      end else if (hit_high) begin
        clip_high_ff <= wr_data[7:afs_pkg::CLIP_FIELD_LSB];
      end else if (hit_fault) begin
        // Only the scale field is writable
        overcurrent_limit_scale_ff <= wr_data[afs_pkg::FLT_SCALE_LSB +: 2];
      end else if (hit_mid) begin
        clip_mid_ff <= wr_data;
      end else if (hit_low) begin
        clip_low_ff <= wr_data[7:afs_pkg::CLIP_FIELD_LSB];
      end
    end
  end

  // Scaled over-current trip level
  wire [afs_pkg::CUR_W-1:0] nom_quarter = afs_pkg::OC_NOMINAL >> 2;
  wire [afs_pkg::CUR_W-1:0] nom_half    = afs_pkg::OC_NOMINAL >> 1;
  wire [afs_pkg::CUR_W-1:0] oc_trip =
    (overcurrent_limit_scale_ff == afs_pkg::SCALE_75) ? afs_pkg::OC_NOMINAL - nom_quarter :
    (overcurrent_limit_scale_ff == afs_pkg::SCALE_50) ? nom_half :
    (overcurrent_limit_scale_ff == afs_pkg::SCALE_25) ? nom_quarter :
    afs_pkg::OC_NOMINAL;

  // Shutdown from either the pin or the run control bit
  wire run_req   = sd_pin_sync & run_ctrl_ff;
  wire leave_sd  = run_req & ~run_prev_ff;
  wire oc_event  = i_out_current > oc_trip;
  wire [NLATCH-1:0] fault_event = {oc_event, pin_sync_ff[1], pin_sync_ff[0]};

  // Latched faults: an event in the clearing cycle still sets the flag
  genvar gi;
  generate
    for (gi = 0; gi < NLATCH; gi = gi + 1) begin : g_latch
      wire nxt_latched = (latched_ff[gi] & ~leave_sd) | fault_event[gi];
      always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
          latched_ff[gi] <= 1'b0;
        end else begin
          latched_ff[gi] <= nxt_latched;
        end
      end
    end
  endgenerate

  // Clock fault tracks the detector, no latching
  wire nxt_amp_run = run_req & ~clk_bad & ~(|latched_ff);

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      clock_fault_flag_ff <= 1'b0;
      run_prev_ff         <= 1'b0;
      amp_run_ff          <= 1'b0;
      clip_level_ff       <= '0;
    end else begin
      clock_fault_flag_ff <= clk_bad;
      run_prev_ff         <= run_req;
      amp_run_ff          <= nxt_amp_run;
      clip_level_ff       <= {clip_high_ff, clip_mid_ff, clip_low_ff};
    end
  end

  // Clipper uses the assembled threshold
  afs_clipper u_clip (
    .i_clk       (i_clk),
    .i_reset     (i_reset),
    .i_valid     (i_sample_valid),
    .i_sample    (i_sample),
    .i_threshold (clip_level_ff),
    .o_valid     (o_sample_valid),
    .o_sample    (o_sample)
  );

  // Open drain: only ever pulls low
  assign o_sda                  = 1'b0;
  assign o_amp_run              = amp_run_ff;
  assign o_clip_threshold_level = clip_level_ff;
  assign o_fault_flags          = {clock_fault_flag_ff, latched_ff};

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence s_mid_write;
    wr_stb && hit_mid;
  endsequence

  sequence s_level_follows;
    ##2 clip_level_ff[13:6] == $past(wr_data, 2);
  endsequence

  a_rsvd_read_zero: assert property (
    hit_fault |-> rd_data[7:6] == 2'h0)
    else $error("fault register top bits not zero");

  a_scale_trip_75: assert property (
    overcurrent_limit_scale_ff == afs_pkg::SCALE_75 |-> oc_event == (i_out_current > 12'h900))
    else $error("75 percent trip level wrong");

  a_scale_trip_50: assert property (
    overcurrent_limit_scale_ff == afs_pkg::SCALE_50 |-> oc_event == (i_out_current > 12'h600))
    else $error("50 percent trip level wrong");

  a_scale_trip_25: assert property (
    overcurrent_limit_scale_ff == afs_pkg::SCALE_25 |-> oc_event == (i_out_current > 12'h300))
    else $error("25 percent trip level wrong");

  a_scale_trip_full: assert property (
    overcurrent_limit_scale_ff == afs_pkg::SCALE_FULL |-> oc_event == (i_out_current > 12'hc00))
    else $error("full trip level wrong");

  a_scale_stable: assert property (
    !(wr_stb && hit_fault) |=> $stable(overcurrent_limit_scale_ff))
    else $error("scale field changed without a write");

  a_clk_flag_follow: assert property (
    clk_bad |=> clock_fault_flag_ff ##1 (clock_fault_flag_ff || !$past(clk_bad)))
    else $error("clock fault flag does not follow detector");

  a_oc_sets: assert property (
    oc_event |=> latched_ff[2] ##1 !amp_run_ff)
    else $error("over-current did not set or did not stop amplifier");

  a_latch_hold: assert property (
    (|latched_ff) && !leave_sd |=> (latched_ff & $past(latched_ff)) == $past(latched_ff))
    else $error("latched fault lost without shutdown toggle");

  a_dc_sets: assert property (
    pin_sync_ff[1] |=> latched_ff[1])
    else $error("offset fault not set");

  a_ot_sets: assert property (
    pin_sync_ff[0] |=> latched_ff[0])
    else $error("over-temperature fault not set");

  a_ro_flags: assert property (
    wr_stb && hit_fault && fault_event == 3'h0 && !leave_sd |=> $stable(latched_ff))
    else $error("write changed read-only flags");

  a_mid_assemble: assert property (
    s_mid_write |-> s_level_follows)
    else $error("threshold bits 13:6 not taken from middle register");

  a_shutdown_stops: assert property (
    !run_req |=> !amp_run_ff)
    else $error("amplifier runs while in shutdown");

  a_toggle_clears: assert property (
    leave_sd && fault_event == 3'h0 |=> latched_ff == 3'h0)
    else $error("shutdown toggle did not clear faults");

  a_clk_flag_clear: assert property (
    !clk_bad |=> !clock_fault_flag_ff)
    else $error("clock fault flag held after clocks recovered");

  a_run_resume: assert property (
    run_req && !clk_bad && latched_ff == 3'h0 |=> amp_run_ff)
    else $error("amplifier did not resume with no fault present");

  a_fault_halts: assert property (
    (|latched_ff) |=> !amp_run_ff)
    else $error("amplifier runs with a latched fault");

  a_low_assemble: assert property (
    wr_stb && hit_low |-> ##2 {clip_level_ff[5:0], 2'h0} == ($past(wr_data, 2) & 8'hfc))
    else $error("threshold bits 5:0 not taken from low register");

endmodule
